//--- hdl/cpmirq_pkg.sv
package cpmirq_pkg;

   // register byte addresses
   localparam logic [7:0] CPMIRQ_IRQ_ENABLE_SET = 8'h00;
   localparam logic [7:0] CPMIRQ_IRQ_ENABLE_CLEAR = 8'h04;
   localparam logic [7:0] CPMIRQ_CLOCK_READINESS_STATUS = 8'h08;
   localparam logic [7:0] CPMIRQ_IRQ_ENABLE_VIEW = 8'h0C;
   localparam logic [7:0] CPMIRQ_OSC_CTRL = 8'h10;
   localparam logic [7:0] CPMIRQ_SYNTH_CONFIG_REG = 8'h14;
   localparam logic [7:0] CPMIRQ_EXT_READY_VIEW = 8'h18;

   // flag positions shared by all four flag registers
   localparam int CPMIRQ_OSC_STABLE_POS = 0;
   localparam int CPMIRQ_SYNTH_LOCK_POS = 2;
   localparam int CPMIRQ_MASTER_CLK_OK_POS = 3;
   localparam int CPMIRQ_PROG_CLK0_OK_POS = 8;
   localparam int CPMIRQ_PROG_CLK_COUNT = 3;
   localparam logic [31:0] CPMIRQ_FLAG_MASK = 32'h0000070D;

   // oscillator control layout
   localparam int CPMIRQ_OSC_ENABLE_POS = 0;
   localparam int CPMIRQ_OSC_BYPASS_POS = 1;
   localparam int CPMIRQ_OSC_COUNT_LSB = 8;
   localparam int CPMIRQ_OSC_COUNT_W = 8;
   localparam int CPMIRQ_OSC_COUNT_SCALE_SHIFT = 3;

   // synthesiser settle field
   localparam int CPMIRQ_SYNTH_COUNT_LSB = 8;
   localparam int CPMIRQ_SYNTH_COUNT_W = 6;
   localparam logic [31:0] CPMIRQ_SYNTH_CONFIG_MASK = 32'h3FFF3FFF;

   // reset values
   localparam logic [31:0] CPMIRQ_ENABLE_RESET = 32'h00000000;
   localparam logic [31:0] CPMIRQ_OSC_CTRL_RESET = 32'h00000000;
   localparam logic [31:0] CPMIRQ_SYNTH_CONFIG_RESET = 32'h00000000;

   // timing
   localparam int CPMIRQ_CLK_HZ = 20000000;
   localparam int CPMIRQ_SLOW_HZ = 32768;
   localparam int CPMIRQ_SLOW_DIV = CPMIRQ_CLK_HZ / CPMIRQ_SLOW_HZ;
   localparam int CPMIRQ_TIMER_W = 16;
   localparam int CPMIRQ_SYNC_STAGES = 3;

endpackage

//--- hdl/cpmirq_timer_if.sv
interface cpmirq_timer_if import cpmirq_pkg::*; ();
   logic start;
   logic abort;
   logic tick;
   logic [CPMIRQ_TIMER_W-1:0] load;
   logic done;

   modport ctrl (output start, output abort, output tick, output load, input done);
   modport timer (input start, input abort, input tick, input load, output done);
endinterface

//--- hdl/cpmirq_settle_timer.sv
module cpmirq_settle_timer
   import cpmirq_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control side
   cpmirq_timer_if.timer tif
);

   typedef struct packed {
      logic [CPMIRQ_TIMER_W-1:0] cnt;
      logic busy;
      logic done;
   } cpmirq_timer_state_t;

   cpmirq_timer_state_t st;
   cpmirq_timer_state_t next_st;

   always_comb begin
      next_st = st;
      if (tif.abort) begin
         next_st.busy = 1'b0;
         next_st.done = 1'b0;
      end else if (tif.start) begin
         // a zero count is ready at once
         next_st.cnt = tif.load;
         next_st.busy = (tif.load != '0);
         next_st.done = (tif.load == '0);
      end else if (st.busy && tif.tick) begin
         next_st.cnt = st.cnt - 1'b1;
         if (st.cnt == {{(CPMIRQ_TIMER_W-1){1'b0}}, 1'b1}) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tif.done = st.done;

endmodule

//--- hdl/cpmirq_top.sv
// Implementation choices: the address-and-strobe port and the address map.
module cpmirq_top
   import cpmirq_pkg::*;
#(
   parameter int SLOW_DIV = CPMIRQ_SLOW_DIV
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // readiness inputs from clock logic
   input wire logic master_clk_ok,
   input wire logic [CPMIRQ_PROG_CLK_COUNT-1:0] prog_clk_ok,
   // interrupt
   output logic irq
);

   localparam int NSYNC = 1 + CPMIRQ_PROG_CLK_COUNT;

   typedef struct packed {
      logic [15:0] slow_cnt;
      logic slow_tick;
      logic [31:0] enable;
      logic [31:0] osc_ctrl;
      logic [31:0] synth_cfg;
      logic [NSYNC-1:0] s1;
      logic [NSYNC-1:0] s2;
      logic [NSYNC-1:0] s3;
      logic [NSYNC-1:0] ext_ok;
      logic [31:0] rdata;
      logic irq;
   } cpmirq_state_t;

   cpmirq_state_t st;
   cpmirq_state_t next_st;

   cpmirq_timer_if osc_tif ();
   cpmirq_timer_if synth_tif ();

   logic [31:0] status;
   logic [NSYNC-1:0] ext_raw;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   cpmirq_settle_timer u_osc_timer (
      .clk(clk),
      .rst(rst),
      .tif(osc_tif)
   );

   cpmirq_settle_timer u_synth_timer (
      .clk(clk),
      .rst(rst),
      .tif(synth_tif)
   );

   assign ext_raw = {prog_clk_ok, master_clk_ok};

   // status word assembly
   always_comb begin
      status = '0;
      status[CPMIRQ_OSC_STABLE_POS] = st.osc_ctrl[CPMIRQ_OSC_BYPASS_POS] | osc_tif.done;
      status[CPMIRQ_SYNTH_LOCK_POS] = synth_tif.done;
      status[CPMIRQ_MASTER_CLK_OK_POS] = st.ext_ok[0];
      status[CPMIRQ_PROG_CLK0_OK_POS +: CPMIRQ_PROG_CLK_COUNT] = st.ext_ok[NSYNC-1:1];
   end

   // timer requests decoded from register writes
   always_comb begin
      osc_tif.tick = st.slow_tick;
      synth_tif.tick = st.slow_tick;
      osc_tif.load = CPMIRQ_TIMER_W'({wdata[CPMIRQ_OSC_COUNT_LSB +: CPMIRQ_OSC_COUNT_W],
                                      {CPMIRQ_OSC_COUNT_SCALE_SHIFT{1'b0}}});
      osc_tif.start = 1'b0;
      osc_tif.abort = 1'b0;
      if (wr && hit(addr, CPMIRQ_OSC_CTRL)) begin
         // bypass or disable stops the count
         if (wdata[CPMIRQ_OSC_BYPASS_POS] || !wdata[CPMIRQ_OSC_ENABLE_POS]) begin
            osc_tif.abort = 1'b1;
         end else if (!st.osc_ctrl[CPMIRQ_OSC_ENABLE_POS] || st.osc_ctrl[CPMIRQ_OSC_BYPASS_POS]) begin
            osc_tif.start = 1'b1;
         end
      end
      // restart settle count on config write
      synth_tif.abort = 1'b0;
      synth_tif.start = wr && hit(addr, CPMIRQ_SYNTH_CONFIG_REG);
      synth_tif.load = CPMIRQ_TIMER_W'(wdata[CPMIRQ_SYNTH_COUNT_LSB +: CPMIRQ_SYNTH_COUNT_W]);
   end

   always_comb begin
      next_st = st;
      // slow clock enable divider
      next_st.slow_tick = 1'b0;
      if (st.slow_cnt == 16'(SLOW_DIV - 1)) begin
         next_st.slow_cnt = '0;
         next_st.slow_tick = 1'b1;
      end else begin
         next_st.slow_cnt = st.slow_cnt + 16'h0001;
      end
      // three stage synchroniser, accepted once stages two and three agree
      next_st.s1 = ext_raw;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < NSYNC; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.ext_ok[i] = st.s3[i];
         end
      end
      if (wr) begin
         if (hit(addr, CPMIRQ_IRQ_ENABLE_SET)) begin
            next_st.enable = st.enable | (wdata & CPMIRQ_FLAG_MASK);
         end
         if (hit(addr, CPMIRQ_IRQ_ENABLE_CLEAR)) begin
            next_st.enable = st.enable & ~(wdata & CPMIRQ_FLAG_MASK);
         end
         if (hit(addr, CPMIRQ_OSC_CTRL)) begin
            next_st.osc_ctrl = wdata & 32'h0000FF03;
         end
         if (hit(addr, CPMIRQ_SYNTH_CONFIG_REG)) begin
            next_st.synth_cfg = wdata & CPMIRQ_SYNTH_CONFIG_MASK;
         end
      end
      // read data stand only in the cycle after the strobe
      next_st.rdata = '0;
      if (rd) begin
         case (addr)
            CPMIRQ_CLOCK_READINESS_STATUS: next_st.rdata = status;
            CPMIRQ_IRQ_ENABLE_VIEW: next_st.rdata = ~st.enable & CPMIRQ_FLAG_MASK;
            CPMIRQ_OSC_CTRL: next_st.rdata = st.osc_ctrl;
            CPMIRQ_SYNTH_CONFIG_REG: next_st.rdata = st.synth_cfg;
            CPMIRQ_EXT_READY_VIEW: next_st.rdata = 32'(st.ext_ok);
            default: next_st.rdata = '0;
         endcase
      end
      next_st.irq = |(status & st.enable);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
         st.enable <= CPMIRQ_ENABLE_RESET;
         st.osc_ctrl <= CPMIRQ_OSC_CTRL_RESET;
         st.synth_cfg <= CPMIRQ_SYNTH_CONFIG_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;
   assign irq = st.irq;

endmodule

//--- verification/cpmirq_asserts.sv
module cpmirq_asserts
   import cpmirq_pkg::*;
#(parameter int SLOW_DIV = 4)
(
   // clock, reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   // readiness, irq
   input wire logic master_clk_ok,
   input wire logic [CPMIRQ_PROG_CLK_COUNT-1:0] prog_clk_ok,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // enables stay clear until a set write, so view and irq are known
   logic no_set;
   always_ff @(posedge clk) no_set <= rst | (no_set & !(wr && addr == 8'h00));
   sequence rd_at(a); rd && addr == a; endsequence
   sequence wr_at(a); wr && addr == a; endsequence
   set_view_a: assert property (
      wr_at(8'h00) ##1 rd_at(8'h0C) |=> (rdata & $past(wdata, 2) & 32'h70D) == 0) else $error("set ignored");
   clr_view_a: assert property (
      wr_at(8'h04) ##1 rd_at(8'h0C) |=> (~rdata & $past(wdata, 2) & 32'h70D) == 0) else $error("clear ignored");
   reserved_zero_a: assert property (
      rd && addr inside {8'h08, 8'h0C} |=> (rdata & ~32'h70D) == 0) else $error("reserved bit set");
   view_reset_a: assert property (
      rd && addr == 8'h0C && no_set |=> rdata == 32'h70D) else $error("enable after reset");
   irq_quiet_a: assert property (
      no_set |-> !irq) else $error("irq without enable");
   master_ok_a: assert property (
      $stable(master_clk_ok) [*7] ##0 rd_at(8'h08) |=> rdata[3] == $past(master_clk_ok)) else $error("master flag");
   prog_ok_a: assert property (
      $stable(prog_clk_ok) [*7] ##0 rd_at(8'h08) |=> rdata[10:8] == $past(prog_clk_ok)) else $error("prog flags");
   bypass_flag_a: assert property (
      wr_at(8'h10) ##0 wdata[1] ##1 rd_at(8'h08) |=> rdata[0]) else $error("bypass flag low");
endmodule
bind cpmirq_top cpmirq_asserts #(.SLOW_DIV(SLOW_DIV)) i_cpmirq_asserts (.clk(clk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .master_clk_ok(master_clk_ok), .prog_clk_ok(prog_clk_ok), .irq(irq));

//--- verification/cpmirq_top_tb.sv
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module cpmirq_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, master_clk_ok = 1'h0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [2:0] prog_clk_ok = 3'h0;
   logic [31:0] rdata;
   logic irq;
   int mismatches = 0, samples_checked = 0;
   cpmirq_top #(.SLOW_DIV(4)) i_cpmirq_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .master_clk_ok(master_clk_ok), .prog_clk_ok(prog_clk_ok), .irq(irq));
   initial begin
      forever #25 clk = ~clk;
   end
   // never call twice in a row: wr would be assigned twice in one step
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   // rdata stands only in the cycle after rd, so look mid-cycle
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      @(negedge clk);
      `CHK("rdata", e, rdata & m)
      @(posedge clk);
   endtask
   task automatic chk_irq(input logic e);
      @(negedge clk);
      `CHK("irq", e, irq)
      @(posedge clk);
   endtask
   task automatic results;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge clk);
      mismatches++;
      results;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      rd_reg(8'h0C, 32'h70D);
      rd_reg(8'h08, 32'h0, 32'hFFFFFFFB);
      rd_reg(8'h00, 32'h0);
      chk_irq(1'h0);
      $display("test reset done");
      master_clk_ok <= 1'h1;
      prog_clk_ok <= 3'h5;
      repeat (6) @(posedge clk);
      rd_reg(8'h08, 32'h508, 32'hFFFFFFFA);
      rd_reg(8'h18, 32'hB);
      wr_reg(8'h00, 32'hFFFFFFFF);
      rd_reg(8'h0C, 32'h0);
      chk_irq(1'h1);
      wr_reg(8'h04, 32'h50C);
      rd_reg(8'h0C, 32'h50C);
      chk_irq(1'h0);
      prog_clk_ok <= 3'h2;
      repeat (6) @(posedge clk);
      chk_irq(1'h1);
      wr_reg(8'h04, 32'h200);
      rd_reg(8'h0C, 32'h70C);
      $display("test enables done");
      wr_reg(8'h10, 32'h2);
      rd_reg(8'h08, 32'h1, 32'h1);
      chk_irq(1'h1);
      wr_reg(8'h10, 32'h0);
      rd_reg(8'h08, 32'h0, 32'h1);
      wr_reg(8'h10, 32'h101);
      rd_reg(8'h08, 32'h0, 32'h1);
      repeat (20) @(posedge clk);
      rd_reg(8'h08, 32'h0, 32'h1);
      repeat (12) @(posedge clk);
      rd_reg(8'h08, 32'h1, 32'h1);
      rd_reg(8'h10, 32'h101);
      $display("test oscillator done");
      wr_reg(8'h00, 32'h4);
      rd_reg(8'h0C, 32'h708);
      wr_reg(8'h14, 32'h200);
      rd_reg(8'h08, 32'h0, 32'h4);
      repeat (10) @(posedge clk);
      rd_reg(8'h08, 32'h4, 32'h4);
      rd_reg(8'h14, 32'h200);
      $display("test lock done");
      rst <= 1'h1;
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      rd_reg(8'h0C, 32'h70D);
      chk_irq(1'h0);
      $display("test second reset done");
      results;
   end
endmodule
